// ==== rtl/tws_event_seq.sv ====
// two-wire bus byte engine with event reporting and scl wait control
// assumes open-drain scl/sda resolved outside, pulled up, and an avalon-mm master on clk_sys
`timescale 1ns/1ps
`default_nettype none

module tws_event_seq (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // avalon-mm register port
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // two-wire bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // bus event
  output logic bus_event_irq
);
  import tws_pkg::*;

  // synchronisers; stage 0 feeds stage 1 only
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_s;
  logic sda_s;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
    end
  end

  assign scl_s = scl_sync_r[1];
  assign sda_s = sda_sync_r[1];

  // state
  logic ack_r, ack_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic spie_r, spie_nxt;
  logic wtim_r, wtim_nxt;
  logic acke_r, acke_nxt;
  logic [7:0] own_r, own_nxt;
  logic [7:0] shift_r, shift_nxt;
  tws_mst_t state_r, state_nxt;
  logic [10:0] tmr_r, tmr_nxt;
  logic scl_lo_r, scl_lo_nxt;
  logic sda_lo_r, sda_lo_nxt;
  logic hold_r, hold_nxt;
  logic [3:0] slot_r, slot_nxt;
  logic addr_ph_r, addr_ph_nxt;
  logic busy_r, busy_nxt;
  logic master_r, master_nxt;
  logic coi_r, coi_nxt;
  logic exc_r, exc_nxt;
  logic trc_r, trc_nxt;
  logic ackd_r, ackd_nxt;
  logic std_r, std_nxt;
  logic spd_r, spd_nxt;
  logic ald_r, ald_nxt;
  logic was_part_r, was_part_nxt;
  logic irq_r, irq_nxt;
  logic scl_drv_r, scl_drv_nxt;

  // decode helpers
  logic wr, rd_stat, wr_ctrl, wr_shift, wr_own, rel;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic part, tx_role, ack_drv, want_lo, tmr_done;
  logic [7:0] status, rx_byte;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata = {24'h000000, rdata_r};
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = ~scl_drv_r;
  assign sda_oe_n = ~sda_lo_r;
  assign bus_event_irq = irq_r;

  always_comb begin
    // bus access decode: every access answers after one wait cycle
    ack_nxt = (avs_read | avs_write) & ~ack_r;
    wr = avs_write & ack_r;
    rd_stat = avs_read & ack_r & (avs_address == OFS_STAT);
    wr_ctrl = wr & (avs_address == OFS_CTRL);
    wr_shift = wr & (avs_address == OFS_SHIFT);
    wr_own = wr & (avs_address == OFS_OWN);

    // line events
    scl_rise = scl_s & ~scl_d_r;
    scl_fall = ~scl_s & scl_d_r;
    start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

    part = master_r | coi_r | exc_r;
    tx_role = addr_ph_r ? master_r : trc_r;
    ack_drv = addr_ph_r ? (~master_r & (coi_r | (exc_r & acke_r))) : (part & ~trc_r & acke_r);
    status = {master_r, ald_r, exc_r, coi_r, trc_r, ackd_r, std_r, spd_r};
    rx_byte = {shift_r[6:0], sda_s};
    tmr_done = (tmr_r >= SCL_HALF_CNT - TMR_ONE);

    // defaults
    spie_nxt = spie_r;
    wtim_nxt = wtim_r;
    acke_nxt = acke_r;
    own_nxt = own_r;
    shift_nxt = shift_r;
    state_nxt = state_r;
    tmr_nxt = tmr_r;
    scl_lo_nxt = scl_lo_r;
    hold_nxt = hold_r;
    slot_nxt = slot_r;
    addr_ph_nxt = addr_ph_r;
    busy_nxt = busy_r;
    master_nxt = master_r;
    coi_nxt = coi_r;
    exc_nxt = exc_r;
    trc_nxt = trc_r;
    ackd_nxt = ackd_r;
    std_nxt = std_r;
    spd_nxt = spd_r;
    ald_nxt = ald_r;
    was_part_nxt = was_part_r;
    irq_nxt = 1'b0;
    rel = 1'b0;

    case (avs_address)
      OFS_CTRL: rdata_nxt = {2'h0, 1'b0, spie_r, wtim_r, acke_r, 2'h0};
      OFS_STAT: rdata_nxt = status;
      OFS_SHIFT: rdata_nxt = shift_r;
      OFS_OWN: rdata_nxt = own_r;
      default: rdata_nxt = 8'h00;
    endcase

    // reading status clears the lost flag; a loss in the same cycle still sets it
    if (rd_stat) begin
      ald_nxt = 1'b0;
    end

    // register writes and wait release
    if (wr_ctrl) begin
      spie_nxt = avs_writedata[CTL_SPIE];
      wtim_nxt = avs_writedata[CTL_WTIM];
      acke_nxt = avs_writedata[CTL_ACKE];
      if (avs_writedata[CTL_WREL]) begin
        rel = 1'b1;
      end
      if (avs_writedata[CTL_STT]) begin
        if (!busy_r && state_r == M_IDLE) begin
          state_nxt = M_START;
          master_nxt = 1'b1;
          tmr_nxt = TMR_ZERO;
        end else if (hold_r && master_r) begin
          state_nxt = M_RST;
          tmr_nxt = TMR_ZERO;
          rel = 1'b1;
        end
      end else if (avs_writedata[CTL_SPT] && hold_r && master_r) begin
        state_nxt = M_STOP_A;
        tmr_nxt = TMR_ZERO;
        rel = 1'b1;
      end
    end
    if (wr_shift) begin
      shift_nxt = avs_writedata[7:0];
      rel = 1'b1;
    end
    if (wr_own) begin
      own_nxt = avs_writedata[7:0];
    end
    if (rel) begin
      hold_nxt = 1'b0;
    end

    // bit sampling on scl rise
    if (scl_rise && busy_r) begin
      if (slot_r <= SLOT_LAST_DATA) begin
        shift_nxt = rx_byte;
        slot_nxt = slot_r + 4'h1;
        if (slot_r == SLOT_FIRST) begin
          ackd_nxt = 1'b0;
          if (!addr_ph_r) begin
            std_nxt = 1'b0;
          end
        end
        // released line read low while sending: arbitration lost, carry on as slave
        if (master_r && tx_role && !sda_lo_r && !sda_s) begin
          master_nxt = 1'b0;
          ald_nxt = 1'b1;
          state_nxt = M_IDLE;
          scl_lo_nxt = 1'b0;
        end
        if (addr_ph_r && slot_r == SLOT_LAST_DATA) begin
          exc_nxt = (rx_byte[7:4] == EXT_CODE);
          coi_nxt = ~master_nxt & (rx_byte[7:4] != EXT_CODE)
                    & (rx_byte[7:1] == own_r[7:1]);
          trc_nxt = master_nxt ? ~rx_byte[0] : rx_byte[0];
        end
      end else if (slot_r == SLOT_ACK) begin
        ackd_nxt = ~sda_s;
        slot_nxt = SLOT_END;
      end
    end

    // events and waits on scl fall
    if (scl_fall && busy_r) begin
      if (slot_r == SLOT_ACK) begin
        if (addr_ph_r) begin
          if (exc_r && !master_r) begin
            irq_nxt = 1'b1;
            hold_nxt = 1'b1;
          end
        end else if (part && !wtim_r) begin
          irq_nxt = 1'b1;
          hold_nxt = 1'b1;
        end
      end else if (slot_r == SLOT_END) begin
        slot_nxt = SLOT_FIRST;
        addr_ph_nxt = 1'b0;
        if (addr_ph_r) begin
          if (master_r || coi_r || (exc_r && wtim_r)) begin
            irq_nxt = 1'b1;
            hold_nxt = 1'b1;
          end else if (!part && was_part_r) begin
            irq_nxt = 1'b1;
          end
        end else if (part && wtim_r) begin
          irq_nxt = 1'b1;
          hold_nxt = 1'b1;
        end
      end
    end

    // master clock and condition generator
    case (state_r)
      M_IDLE: begin
        scl_lo_nxt = 1'b0;
      end
      M_START: begin
        tmr_nxt = tmr_r + TMR_ONE;
        if (tmr_done) begin
          scl_lo_nxt = 1'b1;
          hold_nxt = 1'b1;
          state_nxt = M_XFER;
          tmr_nxt = TMR_ZERO;
        end
      end
      M_XFER: begin
        if (scl_lo_r) begin
          if (!tmr_done) begin
            tmr_nxt = tmr_r + TMR_ONE;
          end else if (!hold_r) begin
            scl_lo_nxt = 1'b0;
            tmr_nxt = TMR_ZERO;
          end
        end else if (!scl_s) begin
          tmr_nxt = TMR_ZERO;
        end else if (tmr_done) begin
          scl_lo_nxt = 1'b1;
          tmr_nxt = TMR_ZERO;
        end else begin
          tmr_nxt = tmr_r + TMR_ONE;
        end
      end
      M_RST: begin
        tmr_nxt = tmr_r + TMR_ONE;
        if (scl_lo_r) begin
          if (tmr_done) begin
            scl_lo_nxt = 1'b0;
            tmr_nxt = TMR_ZERO;
          end
        end else if (!scl_s) begin
          tmr_nxt = TMR_ZERO;
        end else if (tmr_done) begin
          state_nxt = M_START;
          tmr_nxt = TMR_ZERO;
        end
      end
      M_STOP_A: begin
        tmr_nxt = tmr_r + TMR_ONE;
        if (tmr_done) begin
          scl_lo_nxt = 1'b0;
          state_nxt = M_STOP_B;
          tmr_nxt = TMR_ZERO;
        end
      end
      M_STOP_B: begin
        tmr_nxt = scl_s ? tmr_r + TMR_ONE : TMR_ZERO;
        if (scl_s && tmr_done) begin
          state_nxt = M_IDLE;
          tmr_nxt = TMR_ZERO;
        end
      end
      default: begin
        state_nxt = M_IDLE;
        scl_lo_nxt = 1'b0;
        tmr_nxt = TMR_ZERO;
      end
    endcase

    // bus conditions override byte progress
    if (start_det) begin
      busy_nxt = 1'b1;
      std_nxt = 1'b1;
      spd_nxt = 1'b0;
      was_part_nxt = part;
      coi_nxt = 1'b0;
      exc_nxt = 1'b0;
      trc_nxt = 1'b0;
      ackd_nxt = 1'b0;
      slot_nxt = SLOT_FIRST;
      addr_ph_nxt = 1'b1;
      hold_nxt = 1'b0;
    end
    if (stop_det) begin
      busy_nxt = 1'b0;
      spd_nxt = 1'b1;
      std_nxt = 1'b0;
      master_nxt = 1'b0;
      coi_nxt = 1'b0;
      exc_nxt = 1'b0;
      trc_nxt = 1'b0;
      ackd_nxt = 1'b0;
      was_part_nxt = 1'b0;
      hold_nxt = 1'b0;
      slot_nxt = SLOT_FIRST;
      addr_ph_nxt = 1'b0;
      state_nxt = M_IDLE;
      scl_lo_nxt = 1'b0;
      irq_nxt = spie_r;
    end

    // sda only changes while scl is low, outside generated conditions
    if (slot_r == SLOT_ACK) begin
      want_lo = ack_drv;
    end else begin
      want_lo = tx_role & ~shift_r[7];
    end
    case (state_nxt)
      M_START, M_STOP_A, M_STOP_B: sda_lo_nxt = 1'b1;
      M_RST: sda_lo_nxt = 1'b0;
      default: sda_lo_nxt = scl_s ? sda_lo_r : want_lo;
    endcase
    // idle keeps sda while scl is high, so a generated stop must let sda rise here
    if (state_r == M_STOP_B && state_nxt == M_IDLE) begin
      sda_lo_nxt = 1'b0;
    end

    scl_drv_nxt = scl_lo_nxt | hold_nxt;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ack_r <= RST_BIT;
      rdata_r <= RST_BYTE;
      spie_r <= RST_BIT;
      wtim_r <= RST_BIT;
      acke_r <= RST_BIT;
      own_r <= RST_BYTE;
      shift_r <= RST_BYTE;
      state_r <= M_IDLE;
      tmr_r <= TMR_ZERO;
      scl_lo_r <= RST_BIT;
      sda_lo_r <= RST_BIT;
      hold_r <= RST_BIT;
      slot_r <= SLOT_FIRST;
      addr_ph_r <= RST_BIT;
      busy_r <= RST_BIT;
      master_r <= RST_BIT;
      coi_r <= RST_BIT;
      exc_r <= RST_BIT;
      trc_r <= RST_BIT;
      ackd_r <= RST_BIT;
      std_r <= RST_BIT;
      spd_r <= RST_BIT;
      ald_r <= RST_BIT;
      was_part_r <= RST_BIT;
      irq_r <= RST_BIT;
      scl_drv_r <= RST_BIT;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      spie_r <= spie_nxt;
      wtim_r <= wtim_nxt;
      acke_r <= acke_nxt;
      own_r <= own_nxt;
      shift_r <= shift_nxt;
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      scl_lo_r <= scl_lo_nxt;
      sda_lo_r <= sda_lo_nxt;
      hold_r <= hold_nxt;
      slot_r <= slot_nxt;
      addr_ph_r <= addr_ph_nxt;
      busy_r <= busy_nxt;
      master_r <= master_nxt;
      coi_r <= coi_nxt;
      exc_r <= exc_nxt;
      trc_r <= trc_nxt;
      ackd_r <= ackd_nxt;
      std_r <= std_nxt;
      spd_r <= spd_nxt;
      ald_r <= ald_nxt;
      was_part_r <= was_part_nxt;
      irq_r <= irq_nxt;
      scl_drv_r <= scl_drv_nxt;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/tws_pkg.sv ====
// constants, register map and state encoding for the two-wire bus event sequencer
// assumes a 200 MHz system clock and a 32-bit avalon-mm slave port with byte addresses
package tws_pkg;

  // register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_SHIFT = 4'h8;
  localparam logic [3:0] OFS_OWN = 4'hC;

  // bus_control_register fields
  localparam int CTL_WREL = 5;
  localparam int CTL_SPIE = 4;
  localparam int CTL_WTIM = 3;
  localparam int CTL_ACKE = 2;
  localparam int CTL_STT = 1;
  localparam int CTL_SPT = 0;

  // reset values
  localparam logic RST_BIT = 1'b0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // extension codes carry this upper nibble
  localparam logic [3:0] EXT_CODE = 4'h0;

  // bit slots within one byte frame
  localparam logic [3:0] SLOT_FIRST = 4'h0;
  localparam logic [3:0] SLOT_LAST_DATA = 4'h7;
  localparam logic [3:0] SLOT_ACK = 4'h8;
  localparam logic [3:0] SLOT_END = 4'h9;

  // master scl half period: least time, rounded up
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [10:0] SCL_HALF_CNT = 11'(SCL_HALF_CYC);
  localparam logic [10:0] TMR_ZERO = 11'h000;
  localparam logic [10:0] TMR_ONE = 11'h001;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_XFER = 3'b010,
    M_RST = 3'b011,
    M_STOP_A = 3'b100,
    M_STOP_B = 3'b101
  } tws_mst_t;

endpackage

// ==== verif/tb.sv ====
// self-checking bench for the two-wire bus event sequencer
// assumes tws_pkg, the checker and tws_bus_model are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb;
  import tws_pkg::*;
  logic clk_sys;
  logic sys_rst;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic scl_out;
  logic scl_oe_n;
  logic sda_out;
  logic sda_oe_n;
  logic bus_event_irq;
  logic m_scl;
  logic m_sda;
  logic own_ack;
  logic done;
  wire scl;
  wire sda;
  int num_errors;
  int num_checks;
  int irq_cnt;
  // pull-ups: a line is low while any party pulls it
  assign scl = !(!scl_oe_n || m_scl);
  assign sda = !(!sda_oe_n || m_sda);
  tws_event_seq uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .bus_event_irq(bus_event_irq));
  tws_bus_model m (.scl(scl), .sda(sda), .scl_pull(m_scl), .sda_pull(m_sda));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (bus_event_irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("bus answer", 8'h1, 8'(n < 20));
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input string what, input logic [3:0] a, input logic [7:0] mk,
                     input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(what, e, q & mk);
  endtask
  task automatic wait_irq(input int lim);
    int c0;
    int n;
    c0 = irq_cnt;
    n = 0;
    while (irq_cnt == c0 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    chk("event", 8'h1, 8'(irq_cnt != c0));
  endtask
  task automatic t_regs();
    rdc("control", OFS_CTRL, 8'hFF, RST_BYTE);
    rdc("status", OFS_STAT, 8'hFF, RST_BYTE);
    rdc("shift", OFS_SHIFT, 8'hFF, RST_BYTE);
    rdc("own address", OFS_OWN, 8'hFF, RST_BYTE);
    rdc("unmapped", 4'h1, 8'hFF, 8'h00);
  endtask
  task automatic t_master();
    int n;
    m.slv_en = 1'b1;
    wr(OFS_CTRL, 8'h06);
    n = 0;
    while (scl !== 1'b0 && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    wr(OFS_SHIFT, 8'hA0);
    wait_irq(25000);
    chk("fall count", 8'd9, 8'(m.bits));
    rdc("status", OFS_STAT, 8'hF7, 8'h86);
    wr(OFS_SHIFT, 8'h55);
    wait_irq(25000);
    chk("fall count", 8'd8, 8'(m.bits));
    rdc("status", OFS_STAT, 8'hF7, 8'h80);
    // far slave refuses the last byte while scl is held, so the ninth clock sees no ack
    m.slv_en = 1'b0;
    m.sda_pull = 1'b0;
    wr(OFS_CTRL, 8'h2C);
    wait_irq(5000);
    chk("fall count", 8'd9, 8'(m.bits));
    rdc("status", OFS_STAT, 8'hF7, 8'h80);
    wr(OFS_CTRL, 8'h19);
    wait_irq(6000);
    rdc("status", OFS_STAT, 8'hFF, 8'h01);
    m.slv_en = 1'b0;
  endtask
  task automatic t_slave();
    int c0;
    int n;
    wr(OFS_OWN, 8'h66);
    rdc("own address", OFS_OWN, 8'hFE, 8'h66);
    wr(OFS_CTRL, 8'h04);
    fork
      begin
        m.start();
        m.send(8'h66);
        own_ack = m.ack;
        m.send(8'hC3);
        m.start();
        m.send(8'h70);
        m.send(8'h0F);
        m.stop();
        done = 1'b1;
      end
    join_none
    wait_irq(3000);
    rdc("status", OFS_STAT, 8'hFF, 8'h16);
    wr(OFS_SHIFT, 8'hFF);
    wait_irq(3000);
    chk("fall count", 8'd8, 8'(m.bits));
    rdc("status", OFS_STAT, 8'hF7, 8'h10);
    rdc("shift", OFS_SHIFT, 8'hFF, 8'hC3);
    wr(OFS_CTRL, 8'h24);
    wait_irq(3000);
    rdc("status", OFS_STAT, 8'hF7, 8'h02);
    c0 = irq_cnt;
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    repeat (20) @(negedge clk_sys);
    chk("late events", 8'(c0), 8'(irq_cnt));
    rdc("stop flag", OFS_STAT, 8'h01, 8'h01);
    chk("own address ack", 8'h1, {7'h0, own_ack});
  endtask
  task automatic t_ext();
    done = 1'b0;
    wr(OFS_CTRL, 8'h0C);
    fork
      begin
        m.start();
        m.send(8'h08);
        m.send(8'h5A);
        m.stop();
        done = 1'b1;
      end
    join_none
    wait_irq(3000);
    chk("fall count", 8'd8, 8'(m.bits));
    rdc("status", OFS_STAT, 8'hF7, 8'h22);
    wr(OFS_CTRL, 8'h2C);
    wait_irq(3000);
    chk("fall count", 8'd9, 8'(m.bits));
    rdc("status", OFS_STAT, 8'hF7, 8'h26);
    wr(OFS_SHIFT, 8'hFF);
    wait_irq(3000);
    chk("fall count", 8'd9, 8'(m.bits));
    rdc("status", OFS_STAT, 8'hF7, 8'h24);
    rdc("shift", OFS_SHIFT, 8'hFF, 8'h5A);
    wr(OFS_CTRL, 8'h3C);
    wait_irq(3000);
    rdc("status", OFS_STAT, 8'hFF, 8'h01);
  endtask
  task automatic final_report();
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    final_report();
  end
  initial begin
    sys_rst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    own_ack = 1'b0;
    done = 1'b0;
    num_errors = 0;
    num_checks = 0;
    irq_cnt = 0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_master();
    t_slave();
    t_ext();
    final_report();
  end
endmodule

`default_nettype wire

// ==== verif/tws_bus_model.sv ====
// far-side bus party: byte master at a 64 ns link clock, acking slave for the device
// assumes open-drain lines resolved with pull-ups by the bench
`timescale 1ns/1ps
`default_nettype none

module tws_bus_model (
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  // pulls, 1 = line held low
  output logic scl_pull,
  output logic sda_pull
);
  logic slv_en;
  logic ack;
  int bits;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    slv_en = 1'b0;
    bits = 0;
  end
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bits = -1;
    end
  end
  // counts scl falls per byte; as slave it acks on the ninth clock
  always @(negedge scl) begin
    bits = (bits == 9) ? 1 : bits + 1;
    if (slv_en) begin
      sda_pull = (bits == 8);
    end
  end
  // a waiting device stretches the low phase, so wait for the line itself
  task automatic hi();
    scl_pull = 1'b0;
    wait (scl === 1'b1);
    #32;
  endtask
  task automatic start();
    #4;
    sda_pull = 1'b0;
    #32;
    hi();
    sda_pull = 1'b1;
    #32;
    scl_pull = 1'b1;
  endtask
  task automatic send(input logic [7:0] d);
    logic [8:0] w;
    w = {d, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      #4;
      sda_pull = !w[i];
      #28;
      hi();
      if (i == 0) begin
        ack = !sda;
      end
      scl_pull = 1'b1;
    end
  endtask
  task automatic stop();
    #4;
    sda_pull = 1'b1;
    #28;
    hi();
    sda_pull = 1'b0;
    #32;
  endtask
endmodule

`default_nettype wire

// ==== verif/tws_event_seq_assertions.sv ====
// port checker for the two-wire bus event sequencer
// assumes tws_pkg is compiled first; bound to every tws_event_seq
`timescale 1ns/1ps
`default_nettype none

module tws_event_seq_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // bus pins
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic bus_event_irq
);
  import tws_pkg::*;
  logic [3:0] fall_r;
  logic [3:0] fall_nxt;
  logic scl_d_r;
  logic spie_r;
  logic spie_nxt;
  // cycles since the last scl fall, saturating so old falls never look fresh
  always_comb begin
    fall_nxt = (fall_r == 4'hF) ? fall_r : fall_r + 4'h1;
    if (scl_d_r && !scl_in) begin
      fall_nxt = 4'h0;
    end
    spie_nxt = spie_r;
    if (avs_write && !avs_waitrequest && avs_address == OFS_CTRL) begin
      spie_nxt = avs_writedata[CTL_SPIE];
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fall_r <= 4'hF;
      scl_d_r <= 1'b1;
      spie_r <= 1'b0;
    end else begin
      fall_r <= fall_nxt;
      scl_d_r <= scl_in;
      spie_r <= spie_nxt;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("access held past one wait");
  property p_idle_nowait;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_idle_nowait: assert property (p_idle_nowait) else $error("wait without request");
  property p_rd_upper;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_rd_unmapped;
    avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not 0");
  property p_irq_pulse;
    bus_event_irq |=> !bus_event_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("event longer than 1 cycle");
  property p_irq_fall;
    bus_event_irq && !scl_in |-> fall_r <= 4'h8;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("event not at an scl fall");
  property p_stop_gate;
    bus_event_irq && scl_in && sda_in |-> spie_r;
  endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("stop event while disabled");
  property p_open_drain;
    1'b1 |-> !scl_out && !sda_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin drives high");
  c_fall_irq: cover property (bus_event_irq && !scl_in);
  c_stop_irq: cover property (bus_event_irq && scl_in);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule

bind tws_event_seq tws_event_seq_assertions u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .scl_in(scl_in), .scl_out(scl_out), .sda_in(sda_in),
  .sda_out(sda_out), .bus_event_irq(bus_event_irq));

`default_nettype wire
